// ---- fsp_seq_top.sv ----
`include "fsp_map.svh"
`default_nettype none
module fsp_seq_top #(
    parameter int unsigned TICK_CYC = `FSP_TICK_CYC,
    parameter int unsigned PROG_TICKS = `FSP_PROG_TICKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Processor core
    input wire logic core_spm,
    input wire logic core_lpm,
    input wire logic [7:0] core_z_hi,
    input wire logic [7:0] core_z_lo,
    input wire logic [15:0] data_word_regs,
    output logic core_stall,
    output logic lpm_valid,
    output logic [7:0] lpm_data,
    // EEPROM controller status
    input wire logic eeprom_write_busy,
    // Nonvolatile bits, one means programmed
    input wire logic [7:0] fuse_low_prog,
    input wire logic [7:0] fuse_high_prog,
    input wire logic [7:0] ext_fuse_prog,
    input wire logic [7:0] lock_prog,
    // Flash array
    output logic [15:0] flash_rd_addr,
    input wire logic [7:0] flash_rd_data,
    output logic flash_erase,
    output logic flash_write,
    output logic [8:0] flash_page,
    input wire logic [5:0] flash_buf_idx,
    output logic [15:0] flash_buf_data
);
    fsp_pkg::fsp_state_t q;
    fsp_pkg::fsp_state_t d;

    logic [15:0] z;
    logic csr_wr;
    logic code_ok;
    logic fuse_armed;
    logic buf_wr;
    logic buf_clr;
    logic tmr_start;
    logic tmr_done;
    logic [7:0] csr_rd;
    logic [31:0] stat_rd;
    logic [7:0] nv_sel;
    logic buf_rst_n;

    assign z = {core_z_hi, core_z_lo};
    // Byte address straight from the pointer, bit zero included
    assign flash_rd_addr = z;

    assign awready = !q.aw_got && !q.bvalid;
    assign wready = !q.w_got && !q.bvalid;
    assign arready = !q.rvalid;

    assign code_ok = (q.wd[4:0] == `FSP_CODE_FILL) || (q.wd[4:0] == `FSP_CODE_ERASE) ||
        (q.wd[4:0] == `FSP_CODE_WRITE) || (q.wd[4:0] == `FSP_CODE_FUSE) ||
        (q.wd[4:0] == `FSP_CODE_RRE);
    // Past the window, or under an EEPROM write, a load falls back to a plain byte read
    assign fuse_armed = (q.st == fsp_pkg::FSP_ARMED) && (q.cmd == `FSP_CODE_FUSE) && (q.win != 3'h0) &&
        !eeprom_write_busy;

    // Bits 7 and 5 are not implemented, bit 6 (read-while-write busy) always reads zero
    assign csr_rd = {1'b0, 1'b0, 1'b0, q.cmd};
    assign stat_rd = {28'h0000000, eeprom_write_busy, q.op_wr, q.stall, fuse_armed || (q.st == fsp_pkg::FSP_ARMED)};

    always_comb begin
        nv_sel = 8'hff;
        if (z == `FSP_Z_FLB) begin
            nv_sel = ~fuse_low_prog;
        end else if (z == `FSP_Z_LOCK) begin
            nv_sel = ~lock_prog;
        end else if (z == `FSP_Z_EFB) begin
            nv_sel = ~ext_fuse_prog;
        end else if (z == `FSP_Z_FHB) begin
            nv_sel = ~fuse_high_prog;
        end
    end

    always_comb begin
        fsp_pkg::fsp_state_t kept;
        kept = q;
        d = q;
        d.lpm_v = 1'b0;
        csr_wr = 1'b0;
        buf_wr = 1'b0;
        buf_clr = 1'b0;
        tmr_start = 1'b0;

        // Write channel: address and data may arrive in either order
        if (awvalid && awready) begin
            d.aw_got = 1'b1;
            d.aw_a = awaddr;
        end
        if (wvalid && wready) begin
            d.w_got = 1'b1;
            d.wd = wdata;
            d.ws = wstrb;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `FSP_RESP_OKAY;
            if (q.aw_a == `FSP_ADDR_CSR) begin
                csr_wr = q.ws[0];
            end else if (q.aw_a != `FSP_ADDR_STAT) begin
                d.bresp = `FSP_RESP_SLVERR;
            end
        end

        // Read channel
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rresp = `FSP_RESP_OKAY;
            if (araddr == `FSP_ADDR_CSR) begin
                d.rdata = {24'h000000, csr_rd};
            end else if (araddr == `FSP_ADDR_STAT) begin
                d.rdata = stat_rd;
            end else begin
                d.rdata = 32'h00000000;
                d.rresp = `FSP_RESP_SLVERR;
            end
        end

        // Ordinary byte read unless the fuse read is armed
        if (core_lpm && !fuse_armed) begin
            d.lpm_v = 1'b1;
            d.lpm_d = flash_rd_data;
        end

        case (q.st)
            fsp_pkg::FSP_IDLE, fsp_pkg::FSP_ARMED: begin
                if (q.st == fsp_pkg::FSP_ARMED) begin
                    // An EEPROM write that starts inside the window cancels the armed command
                    if (q.win == 3'h0 || eeprom_write_busy) begin
                        d.st = fsp_pkg::FSP_IDLE;
                        d.cmd = 5'h00;
                    end else begin
                        d.win = q.win - 3'h1;
                        if (core_spm) begin
                            d.st = fsp_pkg::FSP_IDLE;
                            d.cmd = 5'h00;
                            if (q.cmd == `FSP_CODE_FILL) begin
                                buf_wr = 1'b1;
                            end else if (q.cmd == `FSP_CODE_ERASE || q.cmd == `FSP_CODE_WRITE) begin
                                // Pointer bits below the page are ignored here
                                tmr_start = 1'b1;
                                d.st = fsp_pkg::FSP_BUSY;
                                d.cmd = q.cmd;
                                d.stall = 1'b1;
                                d.op_wr = (q.cmd == `FSP_CODE_WRITE);
                                d.page = z[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
                            end
                        end else if (core_lpm && fuse_armed) begin
                            d.lpm_v = 1'b1;
                            d.lpm_d = nv_sel;
                            d.st = fsp_pkg::FSP_IDLE;
                            d.cmd = 5'h00;
                        end
                    end
                end
                // EEPROM write in progress blocks every new command
                if (csr_wr && code_ok && !eeprom_write_busy) begin
                    d.st = fsp_pkg::FSP_ARMED;
                    d.cmd = q.wd[4:0];
                    d.win = (q.wd[4:0] == `FSP_CODE_FUSE) ? `FSP_LPM_WIN : `FSP_SPM_WIN;
                    if (q.wd[4:0] == `FSP_CODE_RRE) begin
                        buf_clr = 1'b1;
                    end
                end
            end
            fsp_pkg::FSP_BUSY: begin
                // Command writes are ignored while the array is busy
                if (tmr_done) begin
                    d.st = fsp_pkg::FSP_IDLE;
                    d.cmd = 5'h00;
                    d.stall = 1'b0;
                    buf_clr = q.op_wr;
                end
            end
            default: begin
                d.st = fsp_pkg::FSP_IDLE;
            end
        endcase

        if (!aresetn) begin
            kept = d;
            d = '0;
            // Operation state rides through reset so the array is never left half done
            if (q.st == fsp_pkg::FSP_BUSY) begin
                d.st = kept.st;
                d.cmd = kept.cmd;
                d.stall = kept.stall;
                d.op_wr = kept.op_wr;
                d.page = kept.page;
            end
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    fsp_prog_timer #(
        .TICK_CYC(TICK_CYC),
        .PROG_TICKS(PROG_TICKS)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(tmr_start),
        .done(tmr_done)
    );

    // A running page write still reads the buffer, so reset must not wipe it mid-write
    assign buf_rst_n = aresetn || ((q.st == fsp_pkg::FSP_BUSY) && q.op_wr);

    fsp_page_buf u_buf (
        .aclk(aclk),
        .aresetn(buf_rst_n),
        .wr(buf_wr),
        .clr(buf_clr),
        .wr_idx(z[`FSP_WIDX_MSB:`FSP_WIDX_LSB]),
        .wr_data(data_word_regs),
        .rd_idx(flash_buf_idx),
        .rd_data(flash_buf_data)
    );

    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign core_stall = q.stall;
    assign lpm_valid = q.lpm_v;
    assign lpm_data = q.lpm_d;
    assign flash_erase = (q.st == fsp_pkg::FSP_BUSY) && !q.op_wr;
    assign flash_write = (q.st == fsp_pkg::FSP_BUSY) && q.op_wr;
    assign flash_page = q.page;
endmodule : fsp_seq_top
`default_nettype wire

// ---- fsp_map.svh ----
// What this block does
// - Pattern 00000101 then store instr: page write
// - Core stalled for whole page write
// - Pointer is upper byte and lower byte
// - Word address splits into word and page
// - Load instr reads bytes, bit zero used
// - EEPROM write blocks programming and fuse reads
// - Pointer 0x0001 armed load returns lock bits
// - Fuse arming clears on read or timeout
// - Unarmed load instr is ordinary byte read
// - Pointer 0x0000 armed returns fuse low byte
// - Pointer 0x0003 armed returns fuse high byte
// - Pointer 0x0002 armed returns extended fuse byte
// - Programmed fuse bits read zero, unprogrammed one
// - Flash write in progress survives reset
// - Erase and write timed 3.7 to 4.5 ms
// - Read-while-write busy always reads zero
// - Pattern 00000011 then store instr: page erase
// - Pattern 00000001 then store instr: buffer fill
// - Buffer clears after write, rww enable, reset outside a page write
// - Only five listed low-bit codes accepted
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

`define FSP_ADDR_CSR 32'h0000_0000
`define FSP_ADDR_STAT 32'h0000_0004

`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2

`define FSP_CODE_FILL 5'h01
`define FSP_CODE_ERASE 5'h03
`define FSP_CODE_WRITE 5'h05
`define FSP_CODE_FUSE 5'h09
`define FSP_CODE_RRE 5'h11

`define FSP_Z_FLB 16'h0000
`define FSP_Z_LOCK 16'h0001
`define FSP_Z_EFB 16'h0002
`define FSP_Z_FHB 16'h0003

`define FSP_SPM_WIN 3'h4
`define FSP_LPM_WIN 3'h3

`define FSP_WIDX_LSB 1
`define FSP_WIDX_MSB 6
`define FSP_PAGE_LSB 7
`define FSP_PAGE_MSB 15
`define FSP_BUF_WORDS 64
`define FSP_BUF_ERASED 16'hffff

`define FSP_CLK_MHZ 250
`define FSP_TICK_NS 1000
`define FSP_TICK_CYC (`FSP_TICK_NS * `FSP_CLK_MHZ / 1000)
`define FSP_PROG_MIN_NS 3700000
`define FSP_PROG_MAX_NS 4500000
`define FSP_PROG_TICKS ((`FSP_PROG_MIN_NS + `FSP_TICK_NS - 1) / `FSP_TICK_NS)

`endif

// ---- fsp_pkg.sv ----
`default_nettype none
package fsp_pkg;
    typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_BUSY} fsp_st_t;

    typedef struct packed {
        fsp_st_t st;
        logic [4:0] cmd;
        logic [2:0] win;
        logic op_wr;
        logic [8:0] page;
        logic stall;
        logic lpm_v;
        logic [7:0] lpm_d;
        logic aw_got;
        logic [31:0] aw_a;
        logic w_got;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fsp_state_t;

    typedef struct packed {
        logic run;
        logic [7:0] div;
        logic [11:0] ticks;
        logic done;
    } fsp_tmr_t;

    typedef struct packed {
        logic [63:0][15:0] mem;
        logic [15:0] rd;
    } fsp_buf_t;
endpackage : fsp_pkg
`default_nettype wire

// ---- fsp_prog_timer.sv ----
`include "fsp_map.svh"
`default_nettype none
module fsp_prog_timer #(
    parameter int unsigned TICK_CYC = `FSP_TICK_CYC,
    parameter int unsigned PROG_TICKS = `FSP_PROG_TICKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic done
);
    fsp_pkg::fsp_tmr_t q;
    fsp_pkg::fsp_tmr_t d;

    always_comb begin
        fsp_pkg::fsp_tmr_t kept;
        kept = q;
        d = q;
        d.done = 1'b0;
        if (start && !q.run) begin
            d.run = 1'b1;
            d.div = 8'h00;
            d.ticks = 12'h000;
        end else if (q.run) begin
            // Microsecond tick from the core clock stands in for the RC oscillator
            if (q.div == 8'(TICK_CYC - 1)) begin
                d.div = 8'h00;
                if (q.ticks == 12'(PROG_TICKS - 1)) begin
                    d.run = 1'b0;
                    d.done = 1'b1;
                end else begin
                    d.ticks = q.ticks + 12'h001;
                end
            end else begin
                d.div = q.div + 8'h01;
            end
        end
        if (!aresetn) begin
            kept = d;
            d = '0;
            // A running flash operation is finished even through reset
            if (q.run) begin
                d = kept;
            end
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    assign done = q.done;
endmodule : fsp_prog_timer
`default_nettype wire

// ---- fsp_page_buf.sv ----
`include "fsp_map.svh"
`default_nettype none
module fsp_page_buf (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr,
    input wire logic clr,
    input wire logic [5:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic [5:0] rd_idx,
    output logic [15:0] rd_data
);
    fsp_pkg::fsp_buf_t q;
    fsp_pkg::fsp_buf_t d;
    logic [`FSP_BUF_WORDS-1:0] we;

    genvar gi;
    generate
        for (gi = 0; gi < `FSP_BUF_WORDS; gi++) begin : g_we
            assign we[gi] = wr && (wr_idx == 6'(gi));
        end
    endgenerate

    always_comb begin
        d = q;
        for (int i = 0; i < `FSP_BUF_WORDS; i++) begin
            if (clr || !aresetn) begin
                d.mem[i] = `FSP_BUF_ERASED;
            end else if (we[i]) begin
                d.mem[i] = wr_data;
            end
        end
        d.rd = q.mem[rd_idx];
        if (!aresetn) begin
            d.rd = 16'h0000;
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    assign rd_data = q.rd;
endmodule : fsp_page_buf
`default_nettype wire

// ---- fsp_seq_props.sv ----
`default_nettype none
module fsp_seq_props #(
    parameter int unsigned TICK_CYC = 2,
    parameter int unsigned PROG_TICKS = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_spm,
    input wire logic core_lpm,
    input wire logic [7:0] core_z_hi,
    input wire logic [7:0] core_z_lo,
    input wire logic core_stall,
    input wire logic lpm_valid,
    input wire logic flash_write,
    input wire logic flash_erase,
    input wire logic [15:0] flash_rd_addr,
    input wire logic eeprom_write_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LO = TICK_CYC * PROG_TICKS - 1;
    localparam int unsigned HI = TICK_CYC * PROG_TICKS * 45 / 37 + 2;
    logic [31:0] cnt_q;
    // No reset here: a running operation outlives reset, so must its count
    always_ff @(posedge aclk) begin
        cnt_q <= core_stall ? cnt_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_write_stall: assert property (flash_write |-> core_stall)
        else $error("write without stall");
    chk_erase_stall: assert property (flash_erase |-> core_stall)
        else $error("erase without stall");
    chk_stall_cause: assert property ($rose(core_stall) |-> $past(core_spm))
        else $error("stall without store");
    chk_eeprom_block: assert property ($rose(core_stall) |-> !$past(eeprom_write_busy))
        else $error("started under eeprom write");
    chk_stall_span: assert property ($fell(core_stall) |-> cnt_q >= LO && cnt_q <= HI)
        else $error("operation length off");
    chk_lpm_answer: assert property (core_lpm && !core_stall |=> lpm_valid)
        else $error("load not answered");
    chk_lpm_cause: assert property (lpm_valid |-> $past(core_lpm))
        else $error("stray load answer");
    chk_ptr_join: assert property (flash_rd_addr == {core_z_hi, core_z_lo})
        else $error("pointer halves wrong");
    cover property ($rose(flash_write));
    cover property ($rose(flash_erase));
    cover property (lpm_valid);
endmodule : fsp_seq_props
`default_nettype wire

// ---- fsp_core_model.sv ----
`default_nettype none
module fsp_core_model (
    input wire logic aclk,
    output logic core_spm,
    output logic core_lpm,
    output logic [7:0] core_z_hi,
    output logic [7:0] core_z_lo,
    output logic [15:0] data_word_regs,
    input wire logic lpm_valid,
    input wire logic [7:0] lpm_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {core_spm, core_lpm, core_z_hi, core_z_lo, data_word_regs} = '0;
    end
    // Called right after the arming write is answered, so it lands in the window
    task automatic spm(input logic [15:0] z, input logic [15:0] d);
        {core_z_hi, core_z_lo} <= z;
        data_word_regs <= d;
        core_spm <= 1'h1;
        @(posedge aclk);
        core_spm <= 1'h0;
    endtask : spm
    task automatic lpm(input logic [15:0] z, output logic [7:0] v);
        v = 8'hxx;
        {core_z_hi, core_z_lo} <= z;
        core_lpm <= 1'h1;
        @(posedge aclk);
        core_lpm <= 1'h0;
        repeat (3) begin
            @(posedge aclk);
            if (lpm_valid) v = lpm_data;
        end
    endtask : lpm
endmodule : fsp_core_model
`default_nettype wire

// ---- tb_fsp_seq_top.sv ----
`default_nettype none
module tb_fsp_seq_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic core_spm, core_lpm, core_stall, lpm_valid, eeprom_write_busy, flash_erase, flash_write;
    logic [31:0] awaddr, wdata, araddr, rdata, rdv;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] core_z_hi, core_z_lo, lpm_data, flash_rd_data, v;
    logic [7:0] fz [4];
    logic [15:0] data_word_regs, flash_rd_addr, flash_buf_data;
    logic [8:0] flash_page;
    logic [5:0] flash_buf_idx;
    int fail_count, n_tests;
    fsp_seq_top #(.TICK_CYC(2), .PROG_TICKS(3)) i_fsp_seq_top (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .core_spm, .core_lpm, .core_z_hi, .core_z_lo,
        .data_word_regs, .core_stall, .lpm_valid, .lpm_data, .eeprom_write_busy, .fuse_low_prog(fz[0]),
        .lock_prog(fz[1]), .ext_fuse_prog(fz[2]), .fuse_high_prog(fz[3]), .flash_rd_addr, .flash_rd_data,
        .flash_erase, .flash_write, .flash_page, .flash_buf_idx, .flash_buf_data);
    fsp_core_model i_fsp_core_model (.aclk, .core_spm, .core_lpm, .core_z_hi, .core_z_lo, .data_word_regs,
        .lpm_valid, .lpm_data);
    // Flash array stand-in: value is the XOR of the two address bytes and 0x5a
    function automatic logic [7:0] fl(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : fl
    assign flash_rd_data = fl(flash_rd_addr);
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 100) begin
            fail_count++;
            $display("mismatch wait exp 100 got %0d", n);
            complete_run();
        end
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            tick(n);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        rsp = bresp;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            tick(n);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        rdv = rdata;
        rsp = rresp;
    endtask : rd
    task automatic bufchk(input logic [5:0] k, input logic [15:0] e);
        flash_buf_idx <= k;
        @(posedge aclk);
        @(negedge aclk);
        chk("buffer", 32'(flash_buf_data), 32'(e));
        @(posedge aclk);
    endtask : bufchk
    task automatic wait_idle();
        int n;
        n = 0;
        while (core_stall) tick(n);
    endtask : wait_idle
    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, eeprom_write_busy} = '0;
        {awaddr, wdata, araddr, flash_buf_idx} = '0;
        fz = '{8'h0, 8'h0, 8'h0, 8'h0};
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(32'h0);
        chk("csr", rdv, 32'h0);
        chk("rresp", 32'(rsp), 32'h0);
        rd(32'hc);
        chk("unmapped", 32'(rsp), 32'h2);
        wr(32'hc, 32'h0);
        chk("wresp", 32'(rsp), 32'h2);
        for (int i = 0; i < 4; i++) begin
            fz[i] <= 8'h3c + 8'(i * 37);
            wr(32'h0, 32'h9);
            i_fsp_core_model.lpm(16'(i), v);
            chk("fuse", 32'(v), {24'h0, ~fz[i]});
        end
        rd(32'h0);
        chk("disarm", rdv, 32'h0);
        wr(32'h0, 32'h9);
        repeat (2) @(posedge aclk);
        i_fsp_core_model.lpm(16'h0001, v);
        chk("expired", 32'(v), 32'(fl(16'h0001)));
        i_fsp_core_model.lpm(16'h02a7, v);
        chk("byte", 32'(v), 32'(fl(16'h02a7)));
        eeprom_write_busy <= 1'h1;
        wr(32'h0, 32'h5);
        i_fsp_core_model.spm(16'h0080, 16'h0);
        rd(32'h4);
        chk("blocked", rdv & 32'hf, 32'h8);
        eeprom_write_busy <= 1'h0;
        rd(32'h4);
        chk("eeclear", rdv & 32'h8, 32'h0);
        wr(32'h0, 32'h5);
        eeprom_write_busy <= 1'h1;
        i_fsp_core_model.spm(16'h0080, 16'h0);
        rd(32'h4);
        chk("midwin", rdv & 32'hf, 32'h8);
        eeprom_write_busy <= 1'h0;
        for (int k = 0; k < 64; k += 63) begin
            wr(32'h0, 32'h1);
            i_fsp_core_model.spm({9'h3, 6'(k), 1'h0}, 16'ha500 + 16'(k));
            bufchk(6'(k), 16'ha500 + 16'(k));
        end
        wr(32'h0, 32'h7);
        chk("bresp", 32'(rsp), 32'h0);
        rd(32'h0);
        chk("badcode", rdv, 32'h0);
        wr(32'h0, 32'h5);
        i_fsp_core_model.spm(16'h0180, 16'hdead);
        @(negedge aclk);
        chk("write", 32'({core_stall, flash_write, flash_erase, flash_page}), {20'h0, 3'h6, 9'h3});
        @(posedge aclk);
        rd(32'h0);
        chk("busycsr", rdv & 32'h1f, 32'h5);
        wait_idle();
        rd(32'h0);
        chk("donecsr", rdv, 32'h0);
        bufchk(6'h0, 16'hffff);
        bufchk(6'h3f, 16'hffff);
        wr(32'h0, 32'h3);
        i_fsp_core_model.spm(16'h0180, 16'h0);
        aresetn <= 1'h0;
        @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        chk("erase", 32'({core_stall, flash_erase, flash_page}), {21'h0, 2'h3, 9'h3});
        wait_idle();
        wr(32'h0, 32'h1);
        i_fsp_core_model.spm(16'h000a, 16'h1357);
        bufchk(6'h5, 16'h1357);
        wr(32'h0, 32'h11);
        bufchk(6'h5, 16'hffff);
        complete_run();
    end
endmodule : tb_fsp_seq_top
bind fsp_seq_top fsp_seq_props #(.TICK_CYC(TICK_CYC), .PROG_TICKS(PROG_TICKS)) i_fsp_seq_props (.aclk,
    .aresetn, .core_spm, .core_lpm, .core_z_hi, .core_z_lo, .core_stall, .lpm_valid, .flash_write,
    .flash_erase, .flash_rd_addr, .eeprom_write_busy);
`default_nettype wire
